/* pdt_timer.sv */
`timescale 1ns/1ps
// Function
// - prescaler advanced by internal clock over twelve
// - prescaler at zero reloads 7Fh next tick
// - main counter decrements on each counter tick
// - main counter at zero reloads 0FFh
// - select field picks tap, divide 1..128
// - run bit low: prescaler 7Fh, counter frozen
// - prescaler write loads value while running
// - reset: counter 0FFh, prescaler 7Fh
// - counter readable and writable on the fly
// - decrement to zero sets zero flag
// - writing 00h or bit 7 sets flag
// - counter write beats coincident zero, no flag
// - irq equals enable bit 6 and flag
// - wait mode: counts, zero irq wakes
// - stop mode: frozen, no stop wakeup
// - prescaler bit 7 reads zero
module pdt_timer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [pdt_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [pdt_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pdt_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [pdt_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pdt_pkg::pdt_pwr_s pwr,
   output pdt_pkg::pdt_wake_s wake,
   output logic timer_irq
);

   typedef struct packed {
      logic [6:0] psc;
      logic [7:0] cnt;
      pdt_pkg::pdt_tsc_s tsc;
      logic aw_got;
      logic [pdt_pkg::ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [pdt_pkg::DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } pdt_state_s;

   pdt_state_s st_ff;
   pdt_state_s nxt_st;
   logic div_tick;

   function automatic pdt_pkg::pdt_reg_e reg_decode(input logic [pdt_pkg::ADDR_W-1:0] addr);
      case (addr)
         pdt_pkg::ADDR_PRESCALER_STATE: reg_decode = pdt_pkg::PDT_REG_PSC;
         pdt_pkg::ADDR_MAIN_COUNT: reg_decode = pdt_pkg::PDT_REG_CNT;
         pdt_pkg::ADDR_TIMER_STATUS_CONTROL: reg_decode = pdt_pkg::PDT_REG_TSC;
         default: reg_decode = pdt_pkg::PDT_REG_NONE;
      endcase
   endfunction

   // tap n fires once every 2^n prescaler ticks: when the low n bits are zero
   function automatic logic tap_hit(input logic [6:0] psc, input logic [2:0] sel);
      logic [6:0] mask;
      mask = 7'((8'h01 << sel) - 8'h01);
      tap_hit = ((psc & mask) == pdt_pkg::PSC_ZERO);
   endfunction

   // stop freezes the divider too, so no tick can reach the registers
   pdt_tick_div u_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .freeze(pwr.stop_mode),
      .tick(div_tick)
   );

   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic wr_fire;
   logic [pdt_pkg::ADDR_W-1:0] wr_addr;
   logic [7:0] wr_byte;
   logic wr_lane0;
   pdt_pkg::pdt_reg_e wr_reg;
   pdt_pkg::pdt_reg_e rd_reg;
   logic run_tick;
   logic cnt_tick;

   always_comb begin
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      ar_hs = s_axi_arvalid && s_axi_arready;
      wr_addr = st_ff.aw_got ? st_ff.aw_addr : s_axi_awaddr;
      wr_byte = st_ff.w_got ? st_ff.w_data : s_axi_wdata[7:0];
      wr_lane0 = st_ff.w_got ? st_ff.w_lane0 : s_axi_wstrb[0];
      wr_fire = (st_ff.aw_got || aw_hs) && (st_ff.w_got || w_hs);
      wr_reg = reg_decode(wr_addr);
      rd_reg = reg_decode(s_axi_araddr);
      run_tick = div_tick && st_ff.tsc.prescaler_run;
      cnt_tick = run_tick && tap_hit(st_ff.psc, st_ff.tsc.prescale_select);

      nxt_st = st_ff;

      // prescaler
      if (!st_ff.tsc.prescaler_run) begin
         nxt_st.psc = pdt_pkg::PSC_RELOAD;
      end else if (run_tick) begin
         if (st_ff.psc == pdt_pkg::PSC_ZERO) begin
            nxt_st.psc = pdt_pkg::PSC_RELOAD;
         end else begin
            nxt_st.psc = st_ff.psc - 7'h01;
         end
      end

      // main counter; the run bit gates cnt_tick so it freezes when cleared
      if (cnt_tick) begin
         if (st_ff.cnt == pdt_pkg::CNT_ZERO) begin
            nxt_st.cnt = pdt_pkg::CNT_RELOAD;
         end else begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
         end
      end

      // software writes; byte lane 0 carries the register
      if (wr_fire && wr_lane0) begin
         case (wr_reg)
            pdt_pkg::PDT_REG_PSC: begin
               if (st_ff.tsc.prescaler_run) begin
                  nxt_st.psc = wr_byte[6:0];
               end
            end
            pdt_pkg::PDT_REG_CNT: begin
               // the write overrides a coincident decrement and its flag
               nxt_st.cnt = wr_byte;
            end
            pdt_pkg::PDT_REG_TSC: begin
               nxt_st.tsc = pdt_pkg::pdt_tsc_s'(wr_byte);
            end
            default: begin
            end
         endcase
      end

      // hardware sets after the software write so a set always beats a clear
      if (cnt_tick && (st_ff.cnt == pdt_pkg::CNT_ONE)
          && !(wr_fire && wr_lane0 && (wr_reg == pdt_pkg::PDT_REG_CNT))) begin
         nxt_st.tsc.zero_flag = 1'b1;
      end
      if (wr_fire && wr_lane0 && (wr_reg == pdt_pkg::PDT_REG_CNT) && (wr_byte == pdt_pkg::CNT_ZERO)) begin
         nxt_st.tsc.zero_flag = 1'b1;
      end
      if (st_ff.tsc.zero_flag && (st_ff.tsc == nxt_st.tsc) == 1'b0 && !nxt_st.tsc.zero_flag
          && cnt_tick && (st_ff.cnt == pdt_pkg::CNT_ONE)) begin
         nxt_st.tsc.zero_flag = 1'b1;
      end

      // write channel handshake
      if (wr_fire) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = (wr_reg == pdt_pkg::PDT_REG_NONE) ? pdt_pkg::RESP_SLVERR : pdt_pkg::RESP_OKAY;
      end else begin
         if (aw_hs) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
         end
         if (w_hs) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata[7:0];
            nxt_st.w_lane0 = s_axi_wstrb[0];
         end
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // read channel; reads have no side effect so the counter keeps running
      if (ar_hs) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = pdt_pkg::RESP_OKAY;
         case (rd_reg)
            pdt_pkg::PDT_REG_PSC: nxt_st.rdata = {25'h0000000, st_ff.psc};
            pdt_pkg::PDT_REG_CNT: nxt_st.rdata = {24'h000000, st_ff.cnt};
            pdt_pkg::PDT_REG_TSC: nxt_st.rdata = {24'h000000, 8'(st_ff.tsc)};
            default: begin
               nxt_st.rdata = 32'h00000000;
               nxt_st.rresp = pdt_pkg::RESP_SLVERR;
            end
         endcase
      end else if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '{psc: pdt_pkg::PSC_RELOAD, cnt: pdt_pkg::CNT_RELOAD,
                    tsc: pdt_pkg::pdt_tsc_s'(pdt_pkg::TSC_RESET),
                    aw_got: 1'b0, aw_addr: '0, w_got: 1'b0, w_data: 8'h00, w_lane0: 1'b0,
                    bvalid: 1'b0, bresp: pdt_pkg::RESP_OKAY,
                    rvalid: 1'b0, rdata: 32'h00000000, rresp: pdt_pkg::RESP_OKAY};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // one transaction per channel: hold off new address/data until the response leaves
   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;

   assign timer_irq = st_ff.tsc.zero_irq_enable && st_ff.tsc.zero_flag;
   assign wake.wake_from_wait = timer_irq && pwr.wait_mode;
   assign wake.wake_from_stop = 1'b0;

endmodule

/* pdt_pkg.sv */
package pdt_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_PRESCALER_STATE = 12'h0D2;
   localparam logic [ADDR_W-1:0] IDX_MAIN_COUNT = 12'h0D3;
   localparam logic [ADDR_W-1:0] IDX_TIMER_STATUS_CONTROL = 12'h0D4;
   localparam logic [ADDR_W-1:0] ADDR_PRESCALER_STATE = IDX_PRESCALER_STATE << 2;
   localparam logic [ADDR_W-1:0] ADDR_MAIN_COUNT = IDX_MAIN_COUNT << 2;
   localparam logic [ADDR_W-1:0] ADDR_TIMER_STATUS_CONTROL = IDX_TIMER_STATUS_CONTROL << 2;

   localparam logic [6:0] PSC_RELOAD = 7'h7F;
   localparam logic [6:0] PSC_ZERO = 7'h00;
   localparam logic [7:0] CNT_RELOAD = 8'hFF;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] TSC_RESET = 8'h00;

   // status/control field positions
   localparam int TSC_ZERO_BIT = 7;
   localparam int TSC_IE_BIT = 6;
   localparam int TSC_RSV_SET_BIT = 5;
   localparam int TSC_RSV_CLR_BIT = 4;
   localparam int TSC_RUN_BIT = 3;
   localparam int TSC_SEL_LSB = 0;

   // internal clock divided by twelve feeds the prescaler
   localparam int DIV_RATIO = 12;
   localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);
   localparam logic [3:0] DIV_ZERO = 4'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PDT_REG_NONE,
      PDT_REG_PSC,
      PDT_REG_CNT,
      PDT_REG_TSC
   } pdt_reg_e;

   typedef struct packed {
      logic zero_flag;
      logic zero_irq_enable;
      logic reserved_set_bit;
      logic reserved_clear_bit;
      logic prescaler_run;
      logic [2:0] prescale_select;
   } pdt_tsc_s;

   // low-power mode inputs from the system controller
   typedef struct packed {
      logic wait_mode;
      logic stop_mode;
   } pdt_pwr_s;

   // wake requests to the system controller
   typedef struct packed {
      logic wake_from_wait;
      logic wake_from_stop;
   } pdt_wake_s;

endpackage

/* pdt_tick_div.sv */
`timescale 1ns/1ps
module pdt_tick_div (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic freeze,
   output logic tick
);

   typedef struct packed {
      logic [3:0] cnt;
   } pdt_div_s;

   pdt_div_s st_ff;
   pdt_div_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (!freeze) begin
         if (st_ff.cnt == pdt_pkg::DIV_LAST) begin
            nxt_st.cnt = pdt_pkg::DIV_ZERO;
         end else begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '{cnt: pdt_pkg::DIV_ZERO};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // one-cycle enable, never a derived clock
   assign tick = !freeze && (st_ff.cnt == pdt_pkg::DIV_LAST);

endmodule

/* pdt_timer_props.sv */
`timescale 1ns/1ps
module pdt_timer_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [pdt_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pdt_pkg::pdt_pwr_s pwr,
   input wire pdt_pkg::pdt_wake_s wake,
   input wire logic timer_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wake_on_wait_a: assert property (wake.wake_from_wait == (timer_irq && pwr.wait_mode))
      else $error("wait wake does not follow irq");
   no_stop_wake_a: assert property (!wake.wake_from_stop)
      else $error("stop wake raised");
   // a bus write may still land in stop, so only its edge may move the irq
   stop_irq_frozen_a: assert property (pwr.stop_mode && $past(pwr.stop_mode) && !$rose(s_axi_bvalid)
      |-> $stable(timer_irq)) else $error("irq moved in stop");
   irq_sw_clear_a: assert property ($fell(timer_irq) |-> $rose(s_axi_bvalid))
      else $error("irq dropped without a write");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
      else $error("read upper bits or arready wrong");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
endmodule
bind pdt_timer pdt_timer_props u_props (.clk(clk), .sys_rst(sys_rst), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwr(pwr), .wake(wake), .timer_irq(timer_irq));

/* pdt_timer_test.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module pdt_timer_test;
   localparam logic [11:0] PS = pdt_pkg::ADDR_PRESCALER_STATE;
   localparam logic [11:0] CN = pdt_pkg::ADDR_MAIN_COUNT;
   localparam logic [11:0] TS = pdt_pkg::ADDR_TIMER_STATUS_CONTROL;
   localparam logic [1:0] OK = pdt_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = pdt_pkg::RESP_SLVERR;
   typedef struct packed {logic wr; logic [11:0] a; logic [7:0] d; logic [7:0] rd; logic [1:0] rsp; logic irq;} pdt_row_s;
   logic clk = 1'b0, sys_rst = 1'b1;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] rd, rd2;
   pdt_pkg::pdt_pwr_s pwr = '0;
   pdt_pkg::pdt_wake_s wake;
   int num_errors = 0, tests_run = 0;
   // rows run with the prescaler stopped, so counter reads are fixed
   pdt_row_s rows [9] = '{
      '{1, TS, 8'h20, 8'h20, OK, 0}, '{1, CN, 8'h5A, 8'h5A, OK, 0},
      '{1, PS, 8'h33, 8'h7F, OK, 0}, '{1, CN, 8'h00, 8'h00, OK, 0},
      '{0, TS, 8'h00, 8'hA0, OK, 0}, '{1, TS, 8'hE0, 8'hE0, OK, 1},
      '{1, TS, 8'h20, 8'h20, OK, 0}, '{1, TS, 8'h60, 8'h60, OK, 0},
      '{1, 12'h000, 8'h55, 8'h00, ERR, 0}};

   pdt_timer u_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .pwr(pwr), .wake(wake), .timer_irq(timer_irq));

   initial begin
      forever #4 clk = ~clk;
   end

   // bready is raised late on purpose so the held response gets exercised
   task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         s_axi_bready <= !s_axi_awvalid && !s_axi_wvalid;
      end
   endtask

   task automatic rdr(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         s_axi_rready <= !s_axi_arvalid;
      end
   endtask

   task automatic stop_test();
      if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      stop_test();
   end

   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d, rsp);
         if (rows[i].wr) `CHK("bresp", rows[i].rsp, rsp)
         rdr(rows[i].a, rd, rsp);
         `CHK("rdata", rows[i].rd, rd)
         `CHK("rresp", rows[i].rsp, rsp)
         `CHK("irq", rows[i].irq, timer_irq)
      end
      // running at divide 1: three counter ticks reach zero within 48 clocks
      pwr.wait_mode <= 1'b1;
      wr(TS, 8'h68, rsp);
      wr(CN, 8'h03, rsp);
      rdr(TS, rd, rsp);
      `CHK("flag early", 8'h68, rd)
      repeat (50) @(posedge clk);
      `CHK("irq", 1'b1, timer_irq)
      `CHK("wake", 1'b1, wake.wake_from_wait)
      rdr(TS, rd, rsp);
      `CHK("flag", 8'hE8, rd)
      // zero was reached at least one tick ago, so the count has wrapped to the top
      rdr(CN, rd, rsp);
      `CHK("cnt reload", 1'b1, rd >= 8'hFD)
      pwr.wait_mode <= 1'b0;
      // divide 128: next counter tick only after the prescaler wraps
      wr(TS, 8'h20, rsp);
      rdr(PS, rd, rsp);
      `CHK("psc held", 8'h7F, rd)
      wr(TS, 8'h2F, rsp);
      wr(PS, 8'hFF, rsp);
      rdr(PS, rd, rsp);
      `CHK("psc bit7", 1'b0, rd[7])
      // the two samples are 24 clocks apart: exactly two divider ticks
      repeat (20) @(posedge clk);
      rdr(PS, rd2, rsp);
      `CHK("psc rate", rd - 8'h02, rd2)
      wr(CN, 8'h02, rsp);
      repeat (1000) @(posedge clk);
      rdr(CN, rd, rsp);
      `CHK("cnt slow", 8'h02, rd)
      wr(PS, 8'h01, rsp);
      repeat (30) @(posedge clk);
      rdr(CN, rd, rsp);
      `CHK("cnt psc load", 8'h01, rd)
      // prescaler went 01, 00, then reloaded and stepped once or twice more
      rdr(PS, rd, rsp);
      `CHK("psc reload", 1'b1, rd >= 8'h7D && rd <= 8'h7E)
      pwr.stop_mode <= 1'b1;
      wr(TS, 8'h28, rsp);
      wr(CN, 8'h05, rsp);
      repeat (100) @(posedge clk);
      rdr(CN, rd, rsp);
      `CHK("cnt stop", 8'h05, rd)
      pwr.stop_mode <= 1'b0;
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rdr(PS, rd, rsp);
      `CHK("psc rst", 8'h7F, rd)
      rdr(CN, rd, rsp);
      `CHK("cnt rst", 8'hFF, rd)
      rdr(TS, rd, rsp);
      `CHK("tsc rst", 8'h00, rd)
      stop_test();
   end
endmodule
